// ==== src/srw_pkg.sv ====
// Constants, field layouts and carrier types for the region-one window tracker
package srw_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] SRW_OFS_MEM_CFG = 8'h14;
  localparam logic [7:0] SRW_OFS_BASE = 8'h24;
  localparam logic [7:0] SRW_OFS_WSPAN = 8'h28;
  localparam logic [7:0] SRW_OFS_RSPAN = 8'h2c;
  localparam logic [7:0] SRW_OFS_WR_OFF = 8'h30;
  localparam logic [7:0] SRW_OFS_IN_TALLY = 8'h34;
  localparam logic [7:0] SRW_OFS_RD_OFF = 8'h38;
  localparam logic [7:0] SRW_OFS_OUT_TALLY = 8'h3c;
  localparam logic [7:0] SRW_OFS_SYS_CFG = 8'h40;

  // ==========================================================================
  // Field positions
  localparam int SRW_BIT_REGION_EN = 1;
  localparam int SRW_BIT_WRITE_PROTECT = 7;
  localparam int SRW_SPAN_MSB = 14;
  localparam int SRW_SPAN_LSB = 2;

  // ==========================================================================
  // Values after reset
  localparam logic [29:0] SRW_RST_BASE = 30'h0;
  localparam logic [12:0] SRW_RST_SPAN = 13'h0;
  localparam logic SRW_RST_REGION_EN = 1'b0;
  localparam logic SRW_RST_WRITE_PROTECT = 1'b1;
  localparam logic [15:0] SRW_RST_OFFSET = 16'h0;
  localparam logic [14:0] SRW_RST_TALLY = 15'h0;

  // Tally index per direction
  localparam int SRW_DIR_IN = 0;
  localparam int SRW_DIR_OUT = 1;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] offset;
  } srw_req_t;

  typedef struct packed {
    logic [29:0] base;
    logic [12:0] wspan;
    logic [12:0] rspan;
    logic region_en;
    logic write_protect;
    logic [15:0] wr_off;
    logic [15:0] rd_off;
    logic active;
    logic dir_wr;
    logic [15:0] cur_off;
    logic deny;
    logic stop;
    logic byte_en;
    logic [31:0] addr;
    logic [31:0] rdata;
  } srw_state_t;

  typedef struct packed {
    logic [14:0] count;
  } srw_tally_state_t;

endpackage

// ==== src/srw_tally.sv ====
// Byte tally with clear, step and freeze for one transfer direction
`timescale 1ns/1ps
module srw_tally
  import srw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_step,
  input wire logic i_freeze,
  output logic [14:0] o_count
);

  srw_tally_state_t st_r;
  srw_tally_state_t st_nxt;

  // ==========================================================================
  // Next count: clear beats everything, so a new request never inherits bytes
  always_comb begin
    st_nxt = st_r;
    if (i_clear) begin
      st_nxt.count = SRW_RST_TALLY;
    end else if (i_step && !i_freeze) begin
      st_nxt.count = st_r.count + 15'h1;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r.count <= SRW_RST_TALLY;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_count = st_r.count;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_tally_clear: assert property (i_clear |=> o_count == 15'h0)
    else $error("tally not cleared by request");
  a_tally_frozen: assert property (
    (i_freeze && !i_clear) |=> $stable(o_count))
    else $error("tally moved while frozen");

endmodule

// ==== src/srw_top.sv ====
// Region-one window registers and host transfer tracking
`timescale 1ns/1ps
module srw_top
  import srw_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire srw_req_t I_REQ,
  input wire logic I_BYTE_STB,
  output logic [31:0] O_REG_RDATA,
  output logic O_ACTIVE,
  output logic O_DENY,
  output logic O_STOP_AT_LIMIT,
  output logic O_AHB_BYTE_EN,
  output logic [31:0] O_AHB_ADDR
);

  srw_state_t st_r;
  srw_state_t st_nxt;
  logic [1:0][14:0] tally;
  logic [14:0] tally_sel;
  logic [16:0] cursor;
  logic [16:0] span_bytes;
  logic hit;
  logic req_ok;
  logic [1:0] step;

  // ==========================================================================
  // Window position of the next byte and the end of the active span
  always_comb begin
    tally_sel = st_r.dir_wr ? tally[SRW_DIR_IN] : tally[SRW_DIR_OUT];
    cursor = {1'b0, st_r.cur_off} + {2'b00, tally_sel};
    span_bytes = st_r.dir_wr ? {2'b00, st_r.wspan, 2'b00}
                             : {2'b00, st_r.rspan, 2'b00};
    // No wrap: once the cursor reaches the span end nothing moves on
    hit = st_r.active && (cursor >= span_bytes);
  end

  // ==========================================================================
  // Admission of a new request
  always_comb begin
    if (!st_r.region_en) begin
      req_ok = 1'b0;
    end else if (I_REQ.write) begin
      // A locked or zero-span region refuses host writes
      req_ok = !st_r.write_protect && (st_r.wspan != 13'h0);
    end else begin
      req_ok = (st_r.rspan != 13'h0);
    end
  end

  // ==========================================================================
  // Byte steps go to the tally of the active direction only
  always_comb begin
    step[SRW_DIR_IN] = I_BYTE_STB && !I_REQ.valid && !hit &&
                       st_r.active && st_r.dir_wr;
    step[SRW_DIR_OUT] = I_BYTE_STB && !I_REQ.valid && !hit &&
                        st_r.active && !st_r.dir_wr;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tally
      // Every new request clears both tallies, whatever its direction
      srw_tally u_tally (
        .i_clk(I_CLOCK),
        .i_arst_n(I_ARST_N),
        .i_clear(I_REQ.valid),
        .i_step(step[gi]),
        .i_freeze(hit),
        .o_count(tally[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Next state: registers, request capture, byte forwarding, read data
  always_comb begin
    st_nxt = st_r;
    st_nxt.byte_en = 1'b0;
    // Software writes; the offset and tally registers ignore writes
    if (I_REG_WR) begin
      case (I_REG_ADDR)
        SRW_OFS_MEM_CFG: begin
          st_nxt.region_en = I_REG_WDATA[SRW_BIT_REGION_EN];
        end
        SRW_OFS_BASE: begin
          st_nxt.base = I_REG_WDATA[31:2];
        end
        SRW_OFS_WSPAN: begin
          st_nxt.wspan = I_REG_WDATA[SRW_SPAN_MSB:SRW_SPAN_LSB];
        end
        SRW_OFS_RSPAN: begin
          st_nxt.rspan = I_REG_WDATA[SRW_SPAN_MSB:SRW_SPAN_LSB];
        end
        SRW_OFS_SYS_CFG: begin
          st_nxt.write_protect = I_REG_WDATA[SRW_BIT_WRITE_PROTECT];
        end
        default: begin
        end
      endcase
    end
    // A new request wins over a byte strobe in the same cycle
    if (I_REQ.valid) begin
      if (I_REQ.write) begin
        st_nxt.wr_off = I_REQ.offset;
      end else begin
        st_nxt.rd_off = I_REQ.offset;
      end
      st_nxt.active = req_ok;
      st_nxt.deny = !req_ok;
      st_nxt.dir_wr = I_REQ.write;
      st_nxt.cur_off = I_REQ.offset;
      st_nxt.stop = 1'b0;
    end else begin
      st_nxt.stop = hit;
      if (I_BYTE_STB && st_r.active && !hit) begin
        st_nxt.byte_en = 1'b1;
        st_nxt.addr = {st_r.base, 2'b00} + {15'h0, cursor};
      end
      // Bytes beyond the span are dropped; the host should not send them
    end
    // Read data; unmapped and reserved bits read as zero
    if (I_REG_RD) begin
      case (I_REG_ADDR)
        SRW_OFS_MEM_CFG: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rdata[SRW_BIT_REGION_EN] = st_r.region_en;
        end
        SRW_OFS_BASE: begin
          st_nxt.rdata = {st_r.base, 2'b00};
        end
        SRW_OFS_WSPAN: begin
          st_nxt.rdata = {17'h0, st_r.wspan, 2'b00};
        end
        SRW_OFS_RSPAN: begin
          st_nxt.rdata = {17'h0, st_r.rspan, 2'b00};
        end
        SRW_OFS_WR_OFF: begin
          st_nxt.rdata = {16'h0, st_r.wr_off};
        end
        SRW_OFS_IN_TALLY: begin
          st_nxt.rdata = {17'h0, tally[SRW_DIR_IN]};
        end
        SRW_OFS_RD_OFF: begin
          st_nxt.rdata = {16'h0, st_r.rd_off};
        end
        SRW_OFS_OUT_TALLY: begin
          st_nxt.rdata = {17'h0, tally[SRW_DIR_OUT]};
        end
        SRW_OFS_SYS_CFG: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rdata[SRW_BIT_WRITE_PROTECT] = st_r.write_protect;
        end
        default: begin
          st_nxt.rdata = 32'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_r.base <= SRW_RST_BASE;
      st_r.wspan <= SRW_RST_SPAN;
      st_r.rspan <= SRW_RST_SPAN;
      st_r.region_en <= SRW_RST_REGION_EN;
      st_r.write_protect <= SRW_RST_WRITE_PROTECT;
      st_r.wr_off <= SRW_RST_OFFSET;
      st_r.rd_off <= SRW_RST_OFFSET;
      st_r.active <= 1'b0;
      st_r.dir_wr <= 1'b0;
      st_r.cur_off <= SRW_RST_OFFSET;
      st_r.deny <= 1'b0;
      st_r.stop <= 1'b0;
      st_r.byte_en <= 1'b0;
      st_r.addr <= 32'h0;
      st_r.rdata <= 32'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign O_REG_RDATA = st_r.rdata;
  assign O_ACTIVE = st_r.active;
  assign O_DENY = st_r.deny;
  assign O_STOP_AT_LIMIT = st_r.stop;
  assign O_AHB_BYTE_EN = st_r.byte_en;
  assign O_AHB_ADDR = st_r.addr;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);

  // Register accesses come with one idle cycle between strobes
  a_base_write_lands: assert property (
    (I_REG_WR && I_REG_ADDR == SRW_OFS_BASE) ##1 !I_REG_WR ##1 (I_REG_RD &&
    I_REG_ADDR == SRW_OFS_BASE && !I_REG_WR)
    |=> O_REG_RDATA == ($past(I_REG_WDATA, 3) & 32'hffff_fffc))
    else $error("base readback differs from write");
  a_wspan_readback: assert property (
    (I_REG_WR && I_REG_ADDR == SRW_OFS_WSPAN) ##1 !I_REG_WR ##1 (I_REG_RD &&
    I_REG_ADDR == SRW_OFS_WSPAN && !I_REG_WR)
    |=> O_REG_RDATA == ($past(I_REG_WDATA, 3) & 32'h0000_7ffc))
    else $error("write span readback wrong");
  a_wr_offset_cap: assert property (
    (I_REQ.valid && I_REQ.write) |=> st_r.wr_off == $past(I_REQ.offset))
    else $error("write offset not captured");
  a_rd_offset_cap: assert property (
    (I_REQ.valid && !I_REQ.write) |=> st_r.rd_off == $past(I_REQ.offset)
    && $stable(st_r.wr_off))
    else $error("read offset not captured");
  a_region_gate: assert property (
    (I_REQ.valid && !st_r.region_en) |=> (!O_ACTIVE && O_DENY))
    else $error("disabled region admitted a request");
  a_write_lock: assert property (
    (I_REQ.valid && I_REQ.write && st_r.write_protect) |=> O_DENY)
    else $error("locked region admitted a write");
  a_zero_span: assert property (
    (I_REQ.valid && !I_REQ.write && st_r.rspan == 13'h0) |=> !O_ACTIVE)
    else $error("zero read span admitted a read");
  a_no_byte_past: assert property (
    (hit && !I_REQ.valid) |=> !O_AHB_BYTE_EN)
    else $error("byte forwarded beyond span");
  a_stop_follows: assert property (
    (hit && !I_REQ.valid) |=> O_STOP_AT_LIMIT)
    else $error("stop flag missing at limit");
  a_addr_upward: assert property (
    (O_AHB_BYTE_EN && !I_REQ.valid && I_BYTE_STB && !hit && !I_REG_WR)
    |=> O_AHB_ADDR == $past(O_AHB_ADDR) + 32'h1)
    else $error("address did not climb by one");

endmodule

// ==== sim/srw_host_model.sv ====
// Host-side model that issues transfer requests and byte strobes
`timescale 1ns/1ps
module srw_host_model
  import srw_pkg::*;
(
  input wire logic i_clk,
  output srw_req_t o_req,
  output logic o_byte_stb
);
  // ==========================================================================
  // Idle state at time zero
  initial begin
    o_req = '0;
    o_byte_stb = 1'b0;
  end

  // One request, then n back-to-back byte strobes. The count is chosen by the
  // caller, so an overrun past the span happens only when a test asks for it
  task automatic xfer(input logic w, input logic [15:0] off, input int n);
    @(negedge i_clk);
    o_req = '{valid: 1'b1, write: w, offset: off};
    @(negedge i_clk);
    o_req.valid = 1'b0;
    // Offset is meaningless now; show its inverse so nothing relies on it
    o_req.offset = ~off;
    for (int i = 0; i < n; i++) begin
      o_byte_stb = 1'b1;
      @(negedge i_clk);
    end
    o_byte_stb = 1'b0;
  endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking testbench for the region-one window tracker
`timescale 1ns/1ps
module tb_top
  import srw_pkg::*;
;
  logic clk, arst_n, reg_wr, reg_rd, byte_stb, active, deny, stop, byte_en;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, rdata, ahb_addr, exp_addr, base_b;
  srw_req_t req;
  int err_total, compares, en_cnt;

  // ==========================================================================
  // Clock, design and host model
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  srw_top uut (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_REG_WR(reg_wr),
    .I_REG_RD(reg_rd), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
    .I_REQ(req), .I_BYTE_STB(byte_stb), .O_REG_RDATA(rdata),
    .O_ACTIVE(active), .O_DENY(deny), .O_STOP_AT_LIMIT(stop),
    .O_AHB_BYTE_EN(byte_en), .O_AHB_ADDR(ahb_addr));

  srw_host_model host (.i_clk(clk), .o_req(req), .o_byte_stb(byte_stb));

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Register accesses, one strobe cycle each, driven on the falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(rdata, exp);
  endtask

  // Every forwarded byte must land one address above the previous one
  always @(negedge clk) begin
    if (byte_en === 1'b1) begin
      chk(ahb_addr, exp_addr + 32'(en_cnt));
      en_cnt++;
    end
  end

  // One host transfer, then the outcome seen at the ports
  task automatic run(input logic w, input logic [15:0] off, input int n,
                     input int nexp, input logic dn, input logic st);
    exp_addr = base_b + {16'h0, off};
    en_cnt = 0;
    host.xfer(w, off, n);
    // Let the last forwarded byte and the stop flag settle
    repeat (2) @(negedge clk);
    chk(32'(en_cnt), 32'(nexp));
    chk({31'h0, deny}, {31'h0, dn});
    chk({31'h0, active}, {31'h0, ~dn});
    chk({31'h0, stop}, {31'h0, st});
  endtask

  // ==========================================================================
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #(20 * 5000);
    err_total++;
    test_done();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    exp_addr = 32'h0;
    base_b = 32'h0;
    err_total = 0;
    compares = 0;
    en_cnt = 0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    // Reset values of the whole window and tracking block
    for (int a = 8'h24; a <= 8'h3c; a += 4) begin
      rd(8'(a), 32'h0);
    end
    rd(SRW_OFS_MEM_CFG, 32'h0);
    rd(SRW_OFS_SYS_CFG, 32'h80);
    rd(8'h50, 32'h0);
    // Reserved bits read back zero; read-only places ignore writes
    wr(SRW_OFS_BASE, 32'hffffffff);
    rd(SRW_OFS_BASE, 32'hfffffffc);
    wr(SRW_OFS_WSPAN, 32'hffffffff);
    rd(SRW_OFS_WSPAN, 32'h00007ffc);
    wr(SRW_OFS_RSPAN, 32'hffffffff);
    rd(SRW_OFS_RSPAN, 32'h00007ffc);
    wr(SRW_OFS_WR_OFF, 32'hffffffff);
    rd(SRW_OFS_WR_OFF, 32'h0);
    // Region disabled, then write-protected, then zero spans
    run(1'b1, 16'h1234, 2, 0, 1'b1, 1'b0);
    rd(SRW_OFS_WR_OFF, 32'h00001234);
    wr(SRW_OFS_MEM_CFG, 32'h2);
    rd(SRW_OFS_MEM_CFG, 32'h2);
    run(1'b1, 16'h0000, 2, 0, 1'b1, 1'b0);
    wr(SRW_OFS_SYS_CFG, 32'h0);
    wr(SRW_OFS_WSPAN, 32'h0);
    run(1'b1, 16'h0000, 2, 0, 1'b1, 1'b0);
    wr(SRW_OFS_RSPAN, 32'h0);
    run(1'b0, 16'h0000, 2, 0, 1'b1, 1'b0);
    // Open window: 16 writable bytes, 8 readable bytes
    base_b = 32'h100;
    wr(SRW_OFS_BASE, 32'h100);
    wr(SRW_OFS_WSPAN, 32'h10);
    wr(SRW_OFS_RSPAN, 32'h8);
    // Write overrun: only 12 of 16 bytes fit above offset 4
    run(1'b1, 16'h0004, 16, 12, 1'b0, 1'b1);
    rd(SRW_OFS_IN_TALLY, 32'd12);
    rd(SRW_OFS_WR_OFF, 32'h4);
    // Short read inside the span clears the inbound tally
    run(1'b0, 16'h0002, 3, 3, 1'b0, 1'b0);
    rd(SRW_OFS_IN_TALLY, 32'h0);
    rd(SRW_OFS_OUT_TALLY, 32'd3);
    rd(SRW_OFS_RD_OFF, 32'h2);
    // Read overrun stops at the read span
    run(1'b0, 16'h0000, 10, 8, 1'b0, 1'b1);
    rd(SRW_OFS_OUT_TALLY, 32'd8);
    test_done();
  end
endmodule
